// File: rtl/cap_pkg.sv
// Purpose: Shared constants and types for the card authentication controller
// Assumes: Command codes arrive as one byte from the host command register
// Notes:   Transceive engine, cipher datapath and key store sit outside
// ============================================================
// Constants
package cap_pkg;
    localparam logic [7:0] CMD_IDLE        = 8'h00;
    localparam logic [7:0] CMD_FIRST_AUTH  = 8'h0c;
    localparam logic [7:0] CMD_SECOND_AUTH = 8'h14;
    localparam logic [2:0] FIRST_ARG_BYTES = 3'h6;
    localparam logic       CIPHER_RESET    = 1'b0;

    // ============================================================
    // Types
    typedef enum logic [4:0] {
        CAP_IDLE  = 5'b00001,
        CAP_FETCH = 5'b00010,
        CAP_SEND  = 5'b00100,
        CAP_RECV  = 5'b01000,
        CAP_CHECK = 5'b10000
    } cap_state_t;

    // Request to the shared send/receive engine
    typedef struct packed {
        logic       start;
        logic       from_fifo;
        logic       internal;
        logic [1:0] phase;
    } cap_txrx_req_t;

    // Result returned by the engine and the authentication check
    typedef struct packed {
        logic send_done;
        logic recv_done;
        logic auth_ok;
        logic auth_fail;
    } cap_txrx_rsp_t;
endpackage : cap_pkg

// File: rtl/cap_cipher_flag.sv
// Purpose: Holds the cipher enable bit
// Assumes: Set and clear requests are single-cycle pulses
// Notes:   Host may only clear; setting comes from a good second phase
// ============================================================
// Cipher enable flag
`timescale 1ns/1ps
module cap_cipher_flag (
    input  wire logic ref_clk_in,
    input  wire logic reset_in,
    input  wire logic auth_ok_in,
    input  wire logic auth_fail_in,
    input  wire logic host_clear_in,
    output logic      cipher_enable_bit_out
);
    logic cipher_reg;
    logic cipher_next;

    always_comb
    begin
        cipher_next = cipher_reg;
        if (host_clear_in)
            cipher_next = 1'b0;
        if (auth_fail_in)
            cipher_next = 1'b0;
        // Set wins over a clear in the same cycle
        if (auth_ok_in)
            cipher_next = 1'b1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            cipher_reg <= cap_pkg::CIPHER_RESET;
        else
            cipher_reg <= cipher_next;
    end

    assign cipher_enable_bit_out = cipher_reg;
endmodule : cap_cipher_flag

// File: rtl/card_auth_phase_two_ctrl.sv
// Purpose: Command interpreter for the two authentication phases
// Assumes: Engine pulses send_done and recv_done; check pulses ok/fail
// Notes:   Card replies stay internal and never reach the host FIFO
//
// What this block does
// - Code 14h starts second authentication phase
// - Second phase reads no FIFO arguments
// - Card reply kept internal for authentication
// - Only a host write starts the command
// - Same state sequence as send-then-receive
// - Success sets the cipher enable bit
// - Enabled bit encrypts all later traffic
// - Failure clears the cipher enable bit
// - Host cannot set, only clear, the bit
// - Code 0Ch sends six FIFO bytes
// ============================================================
// Top level
`timescale 1ns/1ps
module card_auth_phase_two_ctrl (
    input  wire logic                   ref_clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   cmd_write_in,
    input  wire logic [7:0]             cmd_code_in,
    input  wire logic                   host_cipher_clear_in,
    input  wire logic                   fifo_valid_in,
    input  wire logic [7:0]             fifo_data_in,
    input  wire cap_pkg::cap_txrx_rsp_t engine_rsp_in,
    output logic                        fifo_pop_out,
    output logic [7:0]                  tx_byte_out,
    output logic                        tx_byte_valid_out,
    output cap_pkg::cap_txrx_req_t      engine_req_out,
    output logic                        reply_to_host_out,
    output logic                        busy_out,
    output logic                        cipher_enable_bit_out,
    output logic                        encrypt_link_out
);
    cap_pkg::cap_state_t state_reg;
    cap_pkg::cap_state_t state_next;
    logic                second_reg;
    logic                second_next;
    logic [2:0]          arg_cnt_reg;
    logic [2:0]          arg_cnt_next;
    logic [7:0]          tx_reg;
    logic [7:0]          tx_next;
    logic                tx_vld_reg;
    logic                tx_vld_next;
    logic                start_reg;
    logic                start_next;
    logic                auth_ok;
    logic                auth_fail;
    logic                abort_cmd;
    logic                last_arg;

    // ============================================================
    // Command decode shared by the groups below
    // Code 00h drops any command in flight; other codes written while
    // busy are ignored with no indication to the host
    assign abort_cmd = cmd_write_in && (cmd_code_in == cap_pkg::CMD_IDLE);
    assign last_arg  = fifo_pop_out
                       && (arg_cnt_reg == cap_pkg::FIRST_ARG_BYTES - 3'h1);

    // ============================================================
    // Command sequencer
    always_comb
    begin
        state_next  = state_reg;
        second_next = second_reg;
        case (state_reg)
            cap_pkg::CAP_IDLE:
            begin
                // Started only by a host write, never internally
                if (cmd_write_in)
                begin
                    if (cmd_code_in == cap_pkg::CMD_SECOND_AUTH)
                    begin
                        second_next = 1'b1;
                        // No argument fetch: data built internally
                        state_next  = cap_pkg::CAP_SEND;
                    end
                    else if (cmd_code_in == cap_pkg::CMD_FIRST_AUTH)
                    begin
                        second_next = 1'b0;
                        state_next  = cap_pkg::CAP_FETCH;
                    end
                end
            end
            cap_pkg::CAP_FETCH:
            begin
                if (last_arg)
                    state_next = cap_pkg::CAP_SEND;
            end
            // Shared send-then-receive sequence
            // Done pulses outside their own state are simply ignored
            cap_pkg::CAP_SEND:
            begin
                if (engine_rsp_in.send_done)
                    state_next = cap_pkg::CAP_RECV;
            end
            cap_pkg::CAP_RECV:
            begin
                if (engine_rsp_in.recv_done)
                    state_next = cap_pkg::CAP_CHECK;
            end
            cap_pkg::CAP_CHECK:
            begin
                // Wait for the internal verdict on the card reply
                if (engine_rsp_in.auth_ok || engine_rsp_in.auth_fail)
                    state_next = cap_pkg::CAP_IDLE;
            end
            default:
                state_next = cap_pkg::CAP_IDLE;
        endcase
        if (abort_cmd)
            state_next = cap_pkg::CAP_IDLE;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            state_reg  <= cap_pkg::CAP_IDLE;
            second_reg <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            second_reg <= second_next;
        end
    end

    // ============================================================
    // Engine start pulse
    // One pulse per command; the engine runs a whole exchange on it
    always_comb
    begin
        start_next = 1'b0;
        if ((state_reg == cap_pkg::CAP_IDLE) && cmd_write_in
            && (cmd_code_in == cap_pkg::CMD_SECOND_AUTH))
            start_next = 1'b1;
        if ((state_reg == cap_pkg::CAP_FETCH) && last_arg)
            start_next = 1'b1;
        // Abort in the sixth pop cycle must not leave a stray start
        if (abort_cmd)
            start_next = 1'b0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            start_reg <= 1'b0;
        else
            start_reg <= start_next;
    end

    // ============================================================
    // First-phase argument bytes
    always_comb
    begin
        arg_cnt_next = arg_cnt_reg;
        tx_next      = tx_reg;
        tx_vld_next  = 1'b0;
        fifo_pop_out = 1'b0;
        // Count restarts while idle, so an aborted fetch leaves no residue
        if (state_reg == cap_pkg::CAP_IDLE)
            arg_cnt_next = 3'h0;
        else if ((state_reg == cap_pkg::CAP_FETCH) && fifo_valid_in)
        begin
            fifo_pop_out = 1'b1;
            tx_next      = fifo_data_in;
            tx_vld_next  = 1'b1;
            arg_cnt_next = arg_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            arg_cnt_reg <= 3'h0;
            tx_reg      <= 8'h00;
            tx_vld_reg  <= 1'b0;
        end
        else
        begin
            arg_cnt_reg <= arg_cnt_next;
            tx_reg      <= tx_next;
            tx_vld_reg  <= tx_vld_next;
        end
    end

    // ============================================================
    // Outcome of the second phase only
    assign auth_ok   = (state_reg == cap_pkg::CAP_CHECK) && second_reg
                       && engine_rsp_in.auth_ok;
    assign auth_fail = (state_reg == cap_pkg::CAP_CHECK) && second_reg
                       && engine_rsp_in.auth_fail
                       && !engine_rsp_in.auth_ok;

    // Host input can only clear; there is no set path from the host
    cap_cipher_flag u_flag (
        .ref_clk_in            (ref_clk_in),
        .reset_in              (reset_in),
        .auth_ok_in            (auth_ok),
        .auth_fail_in          (auth_fail),
        .host_clear_in         (host_cipher_clear_in),
        .cipher_enable_bit_out (cipher_enable_bit_out)
    );

    assign encrypt_link_out  = cipher_enable_bit_out;
    assign reply_to_host_out = 1'b0;
    assign tx_byte_out       = tx_reg;
    assign tx_byte_valid_out = tx_vld_reg;
    assign busy_out          = (state_reg != cap_pkg::CAP_IDLE);

    always_comb
    begin
        engine_req_out.start     = start_reg;
        engine_req_out.from_fifo = !second_reg;
        engine_req_out.internal  = second_reg;
        engine_req_out.phase     = second_reg ? 2'h2 : 2'h1;
    end
endmodule : card_auth_phase_two_ctrl

// File: dv/cap_chk.sv
// Purpose: Port assertions for the auth controller
// Assumes: Engine may answer in any state, even idle after an abort
// Notes:   Bound to every top module instance
`timescale 1ns/1ps
// ========
// Checker
module cap_chk (
    input wire logic                   ref_clk_in,
    input wire logic                   reset_in,
    input wire logic                   cmd_write_in,
    input wire logic [7:0]             cmd_code_in,
    input wire logic                   host_cipher_clear_in,
    input wire cap_pkg::cap_txrx_rsp_t engine_rsp_in,
    input wire logic                   fifo_pop_out,
    input wire cap_pkg::cap_txrx_req_t engine_req_out,
    input wire logic                   reply_to_host_out,
    input wire logic                   busy_out,
    input wire logic                   cipher_enable_bit_out,
    input wire logic                   encrypt_link_out
);
    wire ok  = engine_rsp_in.auth_ok;
    wire fl  = engine_rsp_in.auth_fail;
    wire sec = engine_req_out.internal;
    wire cip = cipher_enable_bit_out;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    a_second_start: assert property (cmd_write_in && !busy_out &&
        cmd_code_in == 8'h14 |=> engine_req_out.start && sec &&
        engine_req_out.phase == 2'h2 && busy_out) else $error("no start");
    a_no_pop: assert property (sec |-> !fifo_pop_out)
        else $error("fifo popped in phase two");
    a_reply_kept: assert property (!reply_to_host_out)
        else $error("reply forwarded");
    a_host_start: assert property ($rose(busy_out) |->
        $past(cmd_write_in)) else $error("busy without write");
    a_busy_ends: assert property ($fell(busy_out) |->
        $past(ok || fl || cmd_write_in)) else $error("early end");
    a_ok_sets: assert property (busy_out && sec && ok |=> cip)
        else $error("bit not set");
    a_link_enc: assert property (encrypt_link_out == cip)
        else $error("link not following bit");
    a_fail_clears: assert property (busy_out && sec && fl && !ok
        |=> !cip) else $error("bit not cleared");
    a_no_set: assert property ($rose(cip) |->
        $past(busy_out && sec && ok)) else $error("bit set wrongly");
    a_start_busy: assert property (engine_req_out.start |-> busy_out)
        else $error("start while idle");
    a_bit_holds: assert property (!ok && !fl &&
        !host_cipher_clear_in |=> $stable(cip)) else $error("bit moved");
endmodule : cap_chk
bind card_auth_phase_two_ctrl cap_chk u_chk (.*);

// File: dv/cap_engine_model.sv
// Purpose: Send/receive engine and card stand-in
// Assumes: One exchange per start pulse
// Notes:   ok_in stands for matching keys
`timescale 1ns/1ps
// ========
// Model
module cap_engine_model (
    input  wire logic                   ref_clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   ok_in,
    input  wire logic [3:0]             dly_in,
    input  wire cap_pkg::cap_txrx_req_t req_in,
    output cap_pkg::cap_txrx_rsp_t      rsp_out
);
    task automatic pulse(input int b);
        repeat (dly_in) @(posedge ref_clk_in);
        #1 rsp_out[b] = 1'b1;
        @(posedge ref_clk_in);
        #1 rsp_out = '0;
    endtask : pulse
    initial
    begin
        rsp_out = '0;
        forever
        begin
            @(posedge ref_clk_in);
            if (req_in.start && !reset_in)
            begin
                pulse(3);
                pulse(2);
                pulse(ok_in ? 1 : 0);
            end
        end
    end
endmodule : cap_engine_model

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the auth controller
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Engine model paces every exchange
`timescale 1ns/1ps
// ========
// Bench
module tb_top;
    logic       ref_clk_in, reset_in, cmd_write_in, host_cipher_clear_in;
    logic       fifo_valid_in, fifo_pop_out, tx_byte_valid_out, ok_in;
    logic       reply_to_host_out, busy_out, encrypt_link_out;
    logic       cipher_enable_bit_out;
    logic [7:0] cmd_code_in, tx_byte_out, req_exp;
    logic [7:0] fifo_data_in = 8'h5a;
    logic [7:0] tx_exp       = 8'h5a;
    logic [3:0] dly_in;
    cap_pkg::cap_txrx_rsp_t engine_rsp_in;
    cap_pkg::cap_txrx_req_t engine_req_out;
    int         fails, n_compared, cyc, pops, starts, txs;
    card_auth_phase_two_ctrl u_dut (.*);
    cap_engine_model u_eng (.ref_clk_in, .reset_in, .ok_in, .dly_in,
        .req_in(engine_req_out), .rsp_out(engine_rsp_in));
    initial
    begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in)
    begin
        cyc++;
        // Each pop shows a fresh head byte, so order is checked too
        if (fifo_pop_out === 1'b1)
        begin
            pops++;
            fifo_data_in <= #1 fifo_data_in + 8'h01;
        end
        if (tx_byte_valid_out === 1'b1)
        begin
            txs++;
            check("tx byte", tx_byte_out, tx_exp);
            tx_exp++;
        end
        if (engine_req_out.start === 1'b1)
        begin
            starts++;
            check("request", 8'(engine_req_out[3:0]), req_exp);
        end
        if (cyc == 3000)
        begin
            fails++;
            wrap_up();
        end
    end
    task automatic check(input string nm, input logic [7:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic run(input logic [7:0] code, input logic ok,
                       input logic [3:0] dly);
        int n;
        ok_in = ok;
        dly_in = dly;
        pops = 0;
        starts = 0;
        txs = 0;
        req_exp = (code == 8'h14) ? 8'h06 : 8'h09;
        cmd_code_in = code;
        cmd_write_in = 1'b1;
        @(posedge ref_clk_in);
        #1 cmd_write_in = 1'b0;
        for (n = 0; busy_out === 1'b1 && n < 200; n++)
            @(posedge ref_clk_in) #1;
        check("busy", busy_out, 8'h00);
        check("starts", 8'(starts), 8'h01);
    endtask : run
    task automatic sc_first(input logic [7:0] bit_exp);
        run(8'h0c, 1'b1, 4'h0);
        check("pops", 8'(pops), 8'h06);
        check("tx count", 8'(txs), 8'h06);
        check("cipher", cipher_enable_bit_out, bit_exp);
    endtask : sc_first
    task automatic sc_second(input logic ok);
        run(8'h14, ok, ok ? 4'h2 : 4'h9);
        check("pops", 8'(pops), 8'h00);
        check("tx count", 8'(txs), 8'h00);
        check("cipher", cipher_enable_bit_out, 8'(ok));
        check("link", encrypt_link_out, 8'(ok));
        check("reply", reply_to_host_out, 8'h00);
    endtask : sc_second
    task automatic sc_clear;
        host_cipher_clear_in = 1'b1;
        @(posedge ref_clk_in);
        #1 host_cipher_clear_in = 1'b0;
        repeat (5) @(posedge ref_clk_in);
        check("cipher", cipher_enable_bit_out, 8'h00);
        check("idle", busy_out, 8'h00);
    endtask : sc_clear
    task automatic sc_abort;
        ok_in = 1'b1;
        dly_in = 4'h0;
        cmd_code_in = 8'h14;
        cmd_write_in = 1'b1;
        @(posedge ref_clk_in);
        #1 cmd_code_in = 8'h00;
        check("busy", busy_out, 8'h01);
        @(posedge ref_clk_in);
        #1 cmd_write_in = 1'b0;
        check("abort", busy_out, 8'h00);
        // Engine still answers ok while idle; the bit must not move
        repeat (10) @(posedge ref_clk_in);
        #1 check("cipher", cipher_enable_bit_out, 8'h00);
    endtask : sc_abort
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial
    begin
        {reset_in, fifo_valid_in, ok_in} = 3'h7;
        {cmd_write_in, host_cipher_clear_in, dly_in} = 6'h00;
        cmd_code_in = 8'h00;
        repeat (3) @(posedge ref_clk_in);
        #1 reset_in = 1'b0;
        check("reset busy", busy_out, 8'h00);
        sc_first(8'h00);
        sc_second(1'b1);
        sc_first(8'h01);
        sc_second(1'b0);
        sc_abort();
        sc_first(8'h00);
        sc_second(1'b1);
        sc_clear();
        wrap_up();
    end
endmodule : tb_top
